// [rtl/chg_pkg.sv]
/*
  constants, state codes and signal groups of the charge cycle sequencer.
  assumes a 100 mhz system clock and a 32-bit classic wishbone register bus.
*/
package chg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_KHZ = 100000;
  localparam int FAULT_PULSE_US = 128;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * (CLK_KHZ / 1000);
  localparam int DETECT_INTERVAL_US = 32000;
  localparam int DETECT_INTERVAL_CYC = DETECT_INTERVAL_US * (CLK_KHZ / 1000);
  localparam int PWM_KHZ = 1500;
  localparam int PWM_DIV_CYC = CLK_KHZ / PWM_KHZ;

  ////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ICHG_OFS = 8'h04;
  localparam logic [7:0] VREG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;

  // control fields
  localparam int STAT_EN_BIT = 0;
  localparam int TERM_EN_BIT = 1;
  localparam int INHIBIT_BIT = 2;
  localparam int RESET_BIT = 3;
  localparam int FLOAT_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h03;

  // current field: fast charge low nibble, termination high nibble
  localparam int ICHG_LSB = 0;
  localparam int TERMINATION_CURRENT_LSB = 4;
  localparam logic [7:0] ICHG_RST = 8'h14;

  // regulation voltage code, 20 mv steps above 3.5 v
  localparam logic [5:0] VREG_RST = 6'h05;
  localparam logic [5:0] VREG_MAX = 6'h2f;

  // status fields
  localparam int MISSING_BIT = 7;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_EVAL = 3'h1,
    ST_SHORT = 3'h2,
    ST_PRE = 3'h3,
    ST_FAST = 3'h4,
    ST_TAPER = 3'h5,
    ST_DETECT = 3'h6,
    ST_DONE = 3'h7
  } chg_state_t;

  typedef struct packed {
    logic vin_valid;
    logic hw_disable_pin;
    logic bat_below_short;
    logic bat_above_min_system_level;
    logic sys_above_reg;
    logic bat_near_reg;
    logic chg_at_term;
    logic bat_below_recharge;
    logic bat_above_detect;
    logic load_over;
    logic fault_event;
  } comp_t;

  localparam int COMP_W = 11;

  typedef struct packed {
    logic batt_switch_full;
    logic batt_switch_linear;
    logic chg_switch_on;
    logic sys_reg_hold;
    logic short_current_on;
    logic detect_sink_on;
    logic supplement_mode;
  } drive_t;

endpackage : chg_pkg

// [rtl/one_shot_timer.sv]
/*
  one-shot interval timer: a start while idle runs it for CYCLES clocks.
  assumes start and abort come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module one_shot_timer #(
  parameter int CYCLES = 16,
  parameter int W = $clog2(CYCLES + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_q;

  // start ignored while running, so only abort cuts a pulse short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        cnt_q <= '0;
      end else if (busy) begin
        if (cnt_q == W'(CYCLES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q + W'(1);
      end else if (start) begin
        busy <= 1'b1;
        cnt_q <= '0;
      end
    end
  end

endmodule : one_shot_timer
`default_nettype wire

// [rtl/charge_cycle_sequencer.sv]
/*
  charge cycle sequencer of a single-cell charger, with wishbone registers,
  open-drain status pins and drive levels for the analog power stage.
  assumes comparator results arrive asynchronously from the analog side.
  //
  // Contract
  // R1 - status pins held low while charging
  // R2 - status pins released when done or disabled
  // R3 - any fault gives one 128 us pulse
  // R4 - status pins act only when enabled
  // R5 - short battery gets short current, rail held
  // R6 - above short threshold, programmed current regulated
  // R7 - battery switch full above minimum system level
  // R8 - rail above regulation: full switch, full current
  // R9 - regulation voltage 3.5 to 4.44 v, taper
  // R10 - low current in taper ends charge, detect
  // R11 - battery found: charge done, rail kept
  // R12 - termination current level is programmable
  // R13 - termination enable clear stops termination
  // R14 - listed events start a new charge cycle
  // R15 - zero charge current and more load: supplement
  // R16 - converter tick at fixed 1.5 mhz
  // R17 - hardware disable pin high forces float mode
  // R18 - detect sink for interval decides presence
  // R19 - inhibit clear and supply present: charge starts
  // R20 - fault pulse counted, never shortened
  // R21 - new cycle returns to phase evaluation
*/
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer
  import chg_pkg::*;
#(
  parameter int FAULT_PULSE_CYCLES = FAULT_PULSE_CYC,
  parameter int DETECT_CYCLES = DETECT_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire comp_t comp_i,
  output logic stat_o,
  output logic stat_oe,
  output logic int_o,
  output logic int_oe,
  output drive_t drive_o,
  output logic [3:0] fast_charge_current_o,
  output logic [3:0] termination_current_o,
  output logic [5:0] batt_regulation_voltage_o,
  output logic pwm_tick_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic [1:0] rst_sync_q;
  logic rst_s_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_q[1];

  logic [COMP_W-1:0] meta_q;
  logic [COMP_W-1:0] sync_q;
  comp_t cs;

  for (genvar i = 0; i < COMP_W; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= comp_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end
  assign cs = comp_t'(sync_q);

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic [4:0] ctrl_q;
  logic [7:0] ichg_q;
  logic [5:0] vreg_q;
  logic missing_q;
  logic ack_q;
  logic [31:0] dat_q;
  chg_state_t state_q;
  chg_state_t state_d;
  logic sink_phase_q;
  drive_t drive_q;
  logic oe_q;

  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_lo = req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = wb_adr_i == CTRL_OFS;
  wire hit_ichg = wb_adr_i == ICHG_OFS;
  wire hit_vreg = wb_adr_i == VREG_OFS;
  wire hit_stat = wb_adr_i == STAT_OFS;
  wire wr_ctrl = wr_lo & hit_ctrl;
  wire [5:0] vreg_wr = (wb_dat_i[5:0] > VREG_MAX) ? VREG_MAX : wb_dat_i[5:0];
  wire [7:0] stat_rd = {missing_q, drive_q.supplement_mode, sink_phase_q, oe_q,
                        1'b0, state_q};
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                       hit_ichg ? {24'h0, ichg_q} :
                       hit_vreg ? {26'h0, vreg_q} :
                       hit_stat ? {24'h0, stat_rd} : 32'h0;

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      dat_q <= req ? rd_mux : 32'h0;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // R12 termination level programmable
  // R9 regulation code clamped to 4.44 v
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctrl_q <= CTRL_RST;
      ichg_q <= ICHG_RST;
      vreg_q <= VREG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[4:0];
      end else begin
        ctrl_q[RESET_BIT] <= 1'b0;
      end
      if (wr_lo & hit_ichg) begin
        ichg_q <= wb_dat_i[7:0];
      end
      if (wr_lo & hit_vreg) begin
        vreg_q <= vreg_wr;
      end
    end
  end

  wire stat_en = ctrl_q[STAT_EN_BIT];
  wire term_en = ctrl_q[TERM_EN_BIT];
  wire inhibit = ctrl_q[INHIBIT_BIT];
  wire float_bit = ctrl_q[FLOAT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // new cycle events
  logic vin_prev_q;
  logic inhibit_prev_q;
  logic float_prev_q;
  logic fault_prev_q;

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      vin_prev_q <= 1'b0;
      inhibit_prev_q <= 1'b0;
      float_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      vin_prev_q <= cs.vin_valid;
      inhibit_prev_q <= inhibit;
      float_prev_q <= float_bit;
      fault_prev_q <= cs.fault_event;
    end
  end

  // R17 disable pin acts as float mode
  // R19 supply present and inhibit clear enables charging
  wire enabled = cs.vin_valid & ~inhibit & ~float_bit & ~cs.hw_disable_pin;
  // R14 recharge, supply, inhibit, reset, float events
  wire new_cycle = (state_q == ST_DONE & cs.bat_below_recharge) |
                   (cs.vin_valid & ~vin_prev_q) |
                   (inhibit ^ inhibit_prev_q) |
                   ctrl_q[RESET_BIT] |
                   (float_bit ^ float_prev_q);

  ////////////////////////////////////////////////////////////////////////
  // interval timers
  logic det_busy;
  logic det_done;
  logic det_start;
  logic det_abort;
  logic pulse_busy;
  logic missing_evt;

  one_shot_timer #(
    .CYCLES(DETECT_CYCLES)
  ) u_detect_timer (
    .clk(clk),
    .rst_n(rst_s_n),
    .start(det_start),
    .abort(det_abort),
    .busy(det_busy),
    .done(det_done)
  );

  // R20 pulse counted, retrigger ignored while busy
  // R3 fault edge or missing battery starts pulse
  one_shot_timer #(
    .CYCLES(FAULT_PULSE_CYCLES)
  ) u_fault_pulse (
    .clk(clk),
    .rst_n(rst_s_n),
    .start((cs.fault_event & ~fault_prev_q) | missing_evt),
    .abort(1'b0),
    .busy(pulse_busy),
    .done()
  );

  ////////////////////////////////////////////////////////////////////////
  // charge state machine
  function automatic chg_state_t pick_phase(input comp_t c);
    if (c.bat_below_short) begin
      pick_phase = ST_SHORT;
    end else if (!c.sys_above_reg) begin
      pick_phase = ST_PRE;
    end else begin
      pick_phase = ST_FAST;
    end
  endfunction : pick_phase

  // R18 battery drops below detect threshold while sinking
  wire sink_fail = state_q == ST_DETECT & sink_phase_q & ~cs.bat_above_detect;
  wire sink_pass = state_q == ST_DETECT & sink_phase_q & det_done;
  wire src_end = state_q == ST_DETECT & ~sink_phase_q & det_done;
  assign missing_evt = sink_fail;

  always_comb begin
    state_d = state_q;
    if (!enabled) begin
      state_d = ST_OFF;
    end else if (new_cycle & state_q != ST_OFF) begin
      // R21 restart from phase evaluation
      state_d = ST_EVAL;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_d = ST_EVAL;
        end
        ST_EVAL: begin
          state_d = pick_phase(cs);
        end
        ST_SHORT: begin
          // R6 above short threshold, regulated current
          if (!cs.bat_below_short) begin
            state_d = cs.sys_above_reg ? ST_FAST : ST_PRE;
          end
        end
        ST_PRE: begin
          // R8 rail above regulation: fast charge
          if (cs.sys_above_reg) begin
            state_d = ST_FAST;
          end
        end
        ST_FAST: begin
          // R9 taper near regulation voltage
          if (cs.bat_near_reg) begin
            state_d = ST_TAPER;
          end
        end
        ST_TAPER: begin
          // R10 termination current reached above recharge
          // R13 no termination when disabled
          if (term_en & cs.chg_at_term & ~cs.bat_below_recharge) begin
            state_d = ST_DETECT;
          end
        end
        ST_DETECT: begin
          // R11 battery held up for the interval
          if (!term_en) begin
            state_d = ST_EVAL;
          end else if (sink_pass) begin
            state_d = ST_DONE;
          end
        end
        ST_DONE: begin
          state_d = ST_DONE;
        end
      endcase
    end
  end

  wire entering = state_d != state_q;
  wire in_timed = state_d == ST_SHORT | state_d == ST_DETECT;
  // R5 short current repeated per detect interval
  assign det_start = in_timed & (entering | ~det_busy | sink_fail);
  assign det_abort = (entering & ~in_timed) | sink_fail;

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_q <= ST_OFF;
      sink_phase_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_d != ST_DETECT | entering) begin
        sink_phase_q <= 1'b1;
      end else if (sink_fail) begin
        sink_phase_q <= 1'b0;
      end else if (src_end) begin
        sink_phase_q <= 1'b1;
      end
    end
  end

  // missing battery flag: write 1 to clear, a new miss wins
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      missing_q <= 1'b0;
    end else if (missing_evt) begin
      missing_q <= 1'b1;
    end else if (sink_pass | (wr_lo & hit_stat & wb_dat_i[MISSING_BIT])) begin
      missing_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power stage drive levels
  wire st_short = state_q == ST_SHORT;
  wire st_pre = state_q == ST_PRE;
  wire st_cc_cv = state_q == ST_FAST | state_q == ST_TAPER;
  wire charging = state_q == ST_EVAL | st_short | st_pre | st_cc_cv;
  wire st_det = state_q == ST_DETECT;
  // R15 supplement when load wants more in any charging state or done, not only at zero charge current
  wire supplement = (charging | state_q == ST_DONE) & cs.load_over;
  drive_t drive_d;

  always_comb begin
    // R7 switch full above minimum level, linear below
    // R8 full switch in fast charge
    drive_d.batt_switch_full = st_cc_cv | (st_pre & cs.bat_above_min_system_level) | supplement;
    drive_d.batt_switch_linear = (st_short | (st_pre & ~cs.bat_above_min_system_level)) & ~supplement;
    drive_d.chg_switch_on = st_short | st_pre | st_cc_cv;
    // R5 rail held during short precharge
    // R11 rail kept regulated when done
    drive_d.sys_reg_hold = st_short | st_pre | state_q == ST_DONE;
    drive_d.short_current_on = st_short | (st_det & ~sink_phase_q);
    // R18 sink the detect current
    drive_d.detect_sink_on = st_det & sink_phase_q;
    drive_d.supplement_mode = supplement;
  end

  ////////////////////////////////////////////////////////////////////////
  // status pins and converter tick
  // R1 low while charging, pulse flips the level
  // R2 released when done or disabled
  // R4 gated by status enable
  wire oe_d = stat_en & (charging ^ pulse_busy);
  logic [$clog2(PWM_DIV_CYC)-1:0] pwm_cnt_q;
  logic pwm_q;
  wire pwm_wrap = pwm_cnt_q == ($clog2(PWM_DIV_CYC))'(PWM_DIV_CYC - 1);

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      oe_q <= 1'b0;
      drive_q <= '0;
      stat_o <= 1'b0;
      int_o <= 1'b0;
      fast_charge_current_o <= 4'h0;
      termination_current_o <= 4'h0;
      batt_regulation_voltage_o <= 6'h0;
    end else begin
      oe_q <= oe_d;
      drive_q <= drive_d;
      stat_o <= 1'b0;
      int_o <= 1'b0;
      fast_charge_current_o <= ichg_q[ICHG_LSB +: 4];
      termination_current_o <= ichg_q[TERMINATION_CURRENT_LSB +: 4];
      batt_regulation_voltage_o <= vreg_q;
    end
  end
  assign stat_oe = oe_q;
  assign int_oe = oe_q;
  assign drive_o = drive_q;

  // R16 fixed converter rate while charging, in detect and when done
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pwm_cnt_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + 1'b1;
      pwm_q <= pwm_wrap & (charging | st_det | state_q == ST_DONE);
    end
  end
  assign pwm_tick_o = pwm_q;

endmodule : charge_cycle_sequencer
`default_nettype wire

// [sim/status_host_model.sv]
/*
  host side of the open-drain status and interrupt lines.
  assumes pull-up resistors on both lines; an undriven line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic int_o,
  input wire logic int_oe,
  output logic stat_line,
  output logic int_line
);
  assign stat_line = stat_oe ? stat_o : 1'b1;
  assign int_line = int_oe ? int_o : 1'b1;
endmodule : status_host_model
`default_nettype wire

// [sim/charge_cycle_checker.sv]
/*
  port checker of the charge cycle sequencer.
  assumes one clock domain; bound to the sequencer at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_checker
  import chg_pkg::*;
#(
  parameter int FAULT_PULSE_CYCLES = 20,
  parameter int DETECT_CYCLES = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire comp_t comp_i,
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire drive_t drive_o,
  input wire logic [3:0] fast_charge_current_o,
  input wire logic [3:0] termination_current_o,
  input wire logic [5:0] batt_regulation_voltage_o,
  input wire logic pwm_tick_o
);
  logic [7:0] gap_q;
  logic seen_q;
  logic [7:0] ichg_q;
  wire wr_ichg = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == ICHG_OFS;
  wire gap_full = gap_q == 8'hff;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
      ichg_q <= 8'h00;
    end else begin
      gap_q <= pwm_tick_o ? 8'h00 : (gap_full ? gap_q : gap_q + 8'h01);
      seen_q <= seen_q | pwm_tick_o;
      ichg_q <= (wr_ichg && wb_ack_o) ? wb_dat_i[7:0] : ichg_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ichg_done; wr_ichg && wb_ack_o; endsequence
  property p_ack_resp; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_pins_pair; stat_oe == int_oe && !stat_o && !int_o; endproperty
  property p_disable_quiet; comp_i.hw_disable_pin [*8] |-> !pwm_tick_o; endproperty
  property p_tick_gap; pwm_tick_o && seen_q |-> gap_q >= 8'd65; endproperty
  property p_detect_switch; drive_o.detect_sink_on |-> !drive_o.chg_switch_on; endproperty
  property p_switch_excl; drive_o.batt_switch_full |-> !drive_o.batt_switch_linear; endproperty
  property p_supp_full; drive_o.supplement_mode |-> drive_o.batt_switch_full; endproperty
  property p_vreg_max; batt_regulation_voltage_o <= VREG_MAX; endproperty
  property p_ichg_copy;
    s_ichg_done |-> ##2 {termination_current_o, fast_charge_current_o} == ichg_q;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_dat_zero: assert property (p_dat_zero)
    else $error("read data outside ack");
  a_pins_pair: assert property (p_pins_pair)
    else $error("status pins disagree");
  a_disable_quiet: assert property (p_disable_quiet)
    else $error("converter ticks while disabled");
  a_tick_gap: assert property (p_tick_gap)
    else $error("converter tick too early");
  a_detect_switch: assert property (p_detect_switch)
    else $error("charge switch on during detect");
  a_switch_excl: assert property (p_switch_excl)
    else $error("battery switch full and linear");
  a_supp_full: assert property (p_supp_full)
    else $error("supplement without full switch");
  a_vreg_max: assert property (p_vreg_max)
    else $error("regulation code above maximum");
  a_ichg_copy: assert property (p_ichg_copy)
    else $error("current fields not copied");
endmodule : charge_cycle_checker

bind charge_cycle_sequencer charge_cycle_checker #(
  .FAULT_PULSE_CYCLES(FAULT_PULSE_CYCLES),
  .DETECT_CYCLES(DETECT_CYCLES)
) chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .comp_i, .stat_o, .stat_oe, .int_o, .int_oe, .drive_o,
  .fast_charge_current_o, .termination_current_o, .batt_regulation_voltage_o, .pwm_tick_o);
`default_nettype wire

// [sim/test_charge_cycle_sequencer.sv]
/*
  self-checking bench of the charge cycle sequencer.
  assumes short pulse and detect counts set through parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module test_charge_cycle_sequencer;
  import chg_pkg::*;
  localparam int FP = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, stat_o, stat_oe, int_o, int_oe, tick, stat_line, int_line;
  comp_t comp = '0;
  drive_t drv;
  logic [3:0] fcc, tcc;
  logic [5:0] vreg;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 51;

  always #5 clk = ~clk;

  charge_cycle_sequencer #(.FAULT_PULSE_CYCLES(FP), .DETECT_CYCLES(30)) uut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .comp_i(comp),
    .stat_o(stat_o), .stat_oe(stat_oe), .int_o(int_o), .int_oe(int_oe), .drive_o(drv),
    .fast_charge_current_o(fcc), .termination_current_o(tcc),
    .batt_regulation_voltage_o(vreg), .pwm_tick_o(tick));
  status_host_model host (.stat_o(stat_o), .stat_oe(stat_oe), .int_o(int_o),
    .int_oe(int_oe), .stat_line(stat_line), .int_line(int_line));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] vclamp(input logic [5:0] v);
    return (v > VREG_MAX) ? VREG_MAX : v;
  endfunction : vclamp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 40) chk(32'h1, 32'h0, "bus silent");
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    xfer(1'b0, a, 32'h0);
    chk(q, e, what);
  endtask : rd

  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      xfer(1'b0, STAT_OFS, 32'h0);
      n++;
    end while (q[2:0] !== s && n < 40);
    chk({29'h0, q[2:0]}, {29'h0, s}, "state");
  endtask : wait_state

  task automatic setc(input comp_t c);
    @(posedge clk);
    comp <= c;
  endtask : setc

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    comp_t c;
    int i;
    int n;
    int hi;
    logic [5:0] v;
    logic [7:0] d;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CTRL_OFS, {27'h0, CTRL_RST}, "ctrl reset");
    rd(ICHG_OFS, {24'h0, ICHG_RST}, "ichg reset");
    rd(VREG_OFS, {26'h0, VREG_RST}, "vreg reset");
    rd(STAT_OFS, 32'h20, "status reset");
    rd(8'h10, 32'h0, "unmapped");
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 6'h30 : ((i == 1) ? 6'h2f : 6'($random(seed)));
      d = 8'($random(seed));
      xfer(1'b1, ICHG_OFS, {24'h0, d});
      xfer(1'b1, VREG_OFS, {26'h0, v});
      rd(VREG_OFS, {26'h0, vclamp(v)}, "vreg");
      chk({24'h0, tcc, fcc}, {24'h0, d}, "ichg out");
      chk({26'h0, vreg}, {26'h0, vclamp(v)}, "vreg out");
    end
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, CTRL_OFS, 32'h7);
      wait_state(3'h0);
      chk({31'h0, stat_oe}, 32'h0, "oe off");
      c = '0;
      c.vin_valid = 1'b1;
      c.bat_below_short = (i == 0);
      c.sys_above_reg = (i == 2);
      c.bat_above_min_system_level = (i == 2);
      setc(c);
      xfer(1'b1, CTRL_OFS, 32'h3);
      wait_state(3'h2 + 3'(i));
      chk({31'h0, stat_oe}, 32'h1, "oe charging");
      chk({29'h0, drv.short_current_on, drv.batt_switch_linear, drv.batt_switch_full},
        (i == 0) ? 32'h6 : ((i == 1) ? 32'h2 : 32'h1), "switches");
    end
    $display("test phases done");
    n = 0;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 200);
    chk(32'(n), 32'(PWM_DIV_CYC), "tick period");
    hi = 0;
    for (n = 0; n < 80; n++) begin
      c.fault_event = (n < 5 || n >= 10);
      comp <= c;
      @(posedge clk);
      if (stat_line === 1'b1) hi++;
    end
    chk(32'(hi), FP, "pulse length");
    xfer(1'b1, CTRL_OFS, 32'h2);
    rd(STAT_OFS, 32'h24, "enable off");
    xfer(1'b1, CTRL_OFS, 32'h3);
    $display("test pins done");
    c.bat_near_reg = 1'b1;
    setc(c);
    wait_state(3'h5);
    xfer(1'b1, CTRL_OFS, 32'h1);
    c.chg_at_term = 1'b1;
    c.bat_above_detect = 1'b1;
    setc(c);
    repeat (20) @(posedge clk);
    rd(STAT_OFS, 32'h35, "no termination");
    xfer(1'b1, CTRL_OFS, 32'h3);
    wait_state(3'h6);
    chk({30'h0, drv.detect_sink_on, drv.chg_switch_on}, 32'h2, "detect drive");
    wait_state(3'h7);
    chk({30'h0, drv.sys_reg_hold, stat_oe}, 32'h2, "done");
    c.bat_below_recharge = 1'b1;
    setc(c);
    wait_state(3'h5);
    $display("test cycle done");
    c.hw_disable_pin = 1'b1;
    setc(c);
    wait_state(3'h0);
    chk({31'h0, stat_oe}, 32'h0, "disabled");
    c.hw_disable_pin = 1'b0;
    setc(c);
    wait_state(3'h5);
    xfer(1'b1, CTRL_OFS, 32'h13);
    wait_state(3'h0);
    xfer(1'b1, CTRL_OFS, 32'h3);
    wait_state(3'h5);
    c.load_over = 1'b1;
    c.bat_near_reg = 1'b0;
    setc(c);
    repeat (6) @(posedge clk);
    chk({30'h0, drv.supplement_mode, drv.batt_switch_full}, 32'h3, "supplement");
    rd(STAT_OFS, 32'h75, "supplement status");
    xfer(1'b1, CTRL_OFS, 32'hb);
    wait_state(3'h4);
    rd(CTRL_OFS, 32'h3, "reset bit clears");
    $display("test disable done");
    report_and_stop();
  end
endmodule : test_charge_cycle_sequencer
`default_nettype wire
